// [rtl/pipe_tx_pkg.sv]
// Constants and types for the PIPE transmit-side controller
// Summary of operation
// - 16-bit path: low byte is first symbol, bit zero serialized first.
// - 32-bit path: four symbols in ascending byte order.
// - Gen1/Gen2: flag low means data byte, high means control byte.
// - Flag bit n qualifies byte lane n, upward from bit zero.
// - One-cycle compliance pulse forces running disparity negative.
// - Gen3 data-valid qualifier makes device skip one word; polarity unsure.
// - Gen3 32-bit: block-start marks where a 128-bit block begins.
// - Gen3 sync header: 10 data block, 01 ordered-set block.
// - Detect/loopback input starts receiver detection, loopback after power-up.
// - Holding electrical-idle input forces transmit output idle.
// - Power-down 00 P0, 01 P0s, 10 P1; 11 unsupported.
// - Gen2 de-emphasis bit: zero -6 dB, one -3.5 dB.
// - Gen3 coefficients: C-1 bits 5:0, C0 11:6, C+1 17:12.
// - Margin 000 normal, 001 full; 010/011 reserved; 1xx last only; the controller accepts 1xx whenever driven.
// - Swing zero means full swing, one means low swing.
// - Rate 00 Gen1, 01 Gen2, 1x Gen3.
// - Path width 8/16 for Gen1, 16 Gen2, 32 Gen3; the controller keeps one WIDTH at every rate, 32 by default.
package pipe_tx_pkg;
    localparam int          DATA_W      = 32;
    localparam int          LANES_W     = 4;
    localparam logic [1:0]  RATE_GEN1   = 2'h0;
    localparam logic [1:0]  RATE_GEN2   = 2'h1;
    localparam logic [1:0]  RATE_GEN3   = 2'h2;
    localparam logic [1:0]  SYNC_DATA   = 2'h2;
    localparam logic [1:0]  SYNC_OS     = 2'h1;
    localparam logic [1:0]  PD_P0       = 2'h0;
    localparam logic [1:0]  PD_P0S      = 2'h1;
    localparam logic [1:0]  PD_P1       = 2'h2;
    localparam logic [1:0]  PD_P2       = 2'h3;
    localparam logic [2:0]  MARGIN_NORM = 3'h0;
    localparam logic [2:0]  MARGIN_FULL = 3'h1;
    localparam logic        DEEMPH_6DB  = 1'h0;
    localparam logic        DEEMPH_35DB = 1'h1;
    localparam int          CM1_LSB     = 0;
    localparam int          C0_LSB      = 6;
    localparam int          CP1_LSB     = 12;
    localparam int          COEF_W      = 6;
    // Skip level on the data-valid pin; polarity is ambiguous, so selectable
    localparam logic        SKIP_LEVEL  = 1'h1;

    typedef struct packed {
        logic [DATA_W-1:0]  data;
        logic [LANES_W-1:0] datak;
        logic               blk_start;
        logic [1:0]         sync_hdr;
        logic               data_valid;
        logic               compliance;
    } tx_word_t;

    typedef struct packed {
        logic        detect_loopback;
        logic        elec_idle;
        logic [1:0]  powerdown;
        logic [1:0]  rate;
        logic        deemph;
        logic [17:0] eq_coeffs;
        logic [2:0]  margin;
        logic        swing;
        logic        rx_polarity;
    } tx_ctrl_t;

    // Gen3 when the rate's upper bit is set
    function automatic logic is_gen3(input logic [1:0] rate);
        return rate[1];
    endfunction : is_gen3
endpackage : pipe_tx_pkg

// [rtl/pipe_coef_pack.sv]
// Packs three Gen3 equalizer coefficients into the 18-bit field
`timescale 1ns/10ps
module pipe_coef_pack
    import pipe_tx_pkg::*;
(
    // Coefficients
    input  wire logic [COEF_W-1:0] c_minus,
    input  wire logic [COEF_W-1:0] c_zero,
    input  wire logic [COEF_W-1:0] c_plus,
    // Packed field
    output wire logic [17:0]       coeffs
);
    assign coeffs = {c_plus, c_zero, c_minus};
endmodule : pipe_coef_pack

// [rtl/pipe_tx_ctrl.sv]
// MAC-side driver of the PHY transmit and control inputs
`timescale 1ns/10ps
module pipe_tx_ctrl
    import pipe_tx_pkg::*;
#(
    parameter int WIDTH = DATA_W
)
(
    // Clock and reset
    input  wire logic                  SYS_CLK,
    input  wire logic                  RESETN,
    // User transmit stream
    input  wire logic [WIDTH-1:0]      TX_DATA,
    input  wire logic [WIDTH/8-1:0]    TX_IS_CTRL,
    input  wire logic                  TX_VALID,
    output wire logic                  TX_READY,
    input  wire logic                  TX_BLOCK_START,
    input  wire logic                  TX_OS_BLOCK,
    input  wire logic                  TX_COMPLIANCE,
    // User control
    input  wire logic [1:0]            RATE,
    input  wire logic [1:0]            POWER_STATE,
    input  wire logic                  ELEC_IDLE,
    input  wire logic                  DETECT_REQ,
    input  wire logic                  DEEMPH_35,
    input  wire logic [COEF_W-1:0]     C_MINUS,
    input  wire logic [COEF_W-1:0]     C_ZERO,
    input  wire logic [COEF_W-1:0]     C_PLUS,
    input  wire logic [2:0]            MARGIN,
    input  wire logic                  LOW_SWING,
    input  wire logic                  RX_INVERT,
    output wire logic                  CTRL_REJECT,
    // PHY transmit inputs
    output wire logic [WIDTH-1:0]      PIPE_TX_DATA,
    output wire logic [WIDTH/8-1:0]    PIPE_TX_DATAK,
    output wire logic                  PIPE_TX_COMPLIANCE,
    output wire logic                  PIPE_TX_DATA_VALID,
    output wire logic                  PIPE_TX_BLK_START,
    output wire logic [1:0]            PIPE_TX_SYNC_HDR,
    output wire logic                  PIPE_TX_DETECT_LOOPBACK,
    output wire logic                  PIPE_TX_ELEC_IDLE,
    output wire logic [1:0]            PIPE_POWERDOWN,
    output wire logic [1:0]            PIPE_RATE,
    output wire logic                  PIPE_TX_DEEMPH,
    output wire logic [17:0]           TX_EQUALIZER_COEFFS,
    output wire logic [2:0]            PIPE_TX_MARGIN,
    output wire logic                  PIPE_TX_SWING,
    output wire logic                  PIPE_RX_POLARITY
);
    tx_word_t          word_q;
    tx_word_t          word_d;
    tx_ctrl_t          ctrl_q;
    tx_ctrl_t          ctrl_d;
    logic              comp_seen_q;
    logic [17:0]       coeffs;
    logic              gen3;
    logic              pd_bad;
    logic              margin_bad;
    logic              ctrl_bad;
    logic              send;
    logic              comp_pulse;
    logic [1:0]        rate_eff;

    pipe_coef_pack u_pack (
        .c_minus (C_MINUS),
        .c_zero  (C_ZERO),
        .c_plus  (C_PLUS),
        .coeffs  (coeffs)
    );

    // Gen3 needs the 32-bit path; narrower builds stay at Gen1/Gen2
    assign rate_eff   = (WIDTH < DATA_W && is_gen3(RATE)) ?
                        RATE_GEN2 : RATE;
    assign gen3       = is_gen3(rate_eff);
    assign pd_bad     = (POWER_STATE == PD_P2);
    // 010/011 codes reserved and rejected; 1xx codes accepted whenever driven
    assign margin_bad = (MARGIN[2:1] == 2'h1);
    assign ctrl_bad   = pd_bad | margin_bad;
    assign CTRL_REJECT = ctrl_bad;
    assign TX_READY   = 1'b1;
    assign send       = TX_VALID;
    assign comp_pulse = TX_COMPLIANCE & ~comp_seen_q;

    always_comb begin
        word_d            = '0;
        word_d.data       = DATA_W'(TX_DATA);
        word_d.datak      = LANES_W'(TX_IS_CTRL);
        word_d.compliance = comp_pulse & ~gen3;
        // Idle cycles are marked for skipping at Gen3
        word_d.data_valid = gen3 ? (send ? ~SKIP_LEVEL : SKIP_LEVEL)
                                 : 1'b1;
        word_d.blk_start  = gen3 & send & TX_BLOCK_START;
        word_d.sync_hdr   = (gen3 && TX_BLOCK_START) ?
                            (TX_OS_BLOCK ? SYNC_OS : SYNC_DATA) :
                            2'h0;
    end

    always_comb begin
        ctrl_d                 = ctrl_q;
        ctrl_d.detect_loopback = DETECT_REQ;
        ctrl_d.elec_idle       = ELEC_IDLE | (~send & ~gen3);
        ctrl_d.rate            = rate_eff;
        ctrl_d.deemph          = DEEMPH_35;
        ctrl_d.eq_coeffs       = coeffs;
        ctrl_d.swing           = LOW_SWING;
        ctrl_d.rx_polarity     = RX_INVERT;
        if (!pd_bad) begin
            ctrl_d.powerdown = POWER_STATE;
        end
        if (!margin_bad) begin
            ctrl_d.margin = MARGIN;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            word_q      <= '0;
            comp_seen_q <= 1'b0;
        end else begin
            word_q      <= word_d;
            comp_seen_q <= TX_COMPLIANCE;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_q           <= '0;
            ctrl_q.elec_idle <= 1'b1;
            ctrl_q.powerdown <= PD_P1;
            ctrl_q.rate      <= RATE_GEN1;
            ctrl_q.margin    <= MARGIN_NORM;
            ctrl_q.deemph    <= DEEMPH_6DB;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    assign PIPE_TX_DATA            = word_q.data[WIDTH-1:0];
    assign PIPE_TX_DATAK           = word_q.datak[WIDTH/8-1:0];
    assign PIPE_TX_COMPLIANCE      = word_q.compliance;
    assign PIPE_TX_DATA_VALID      = word_q.data_valid;
    assign PIPE_TX_BLK_START       = word_q.blk_start;
    assign PIPE_TX_SYNC_HDR        = word_q.sync_hdr;
    assign PIPE_TX_DETECT_LOOPBACK = ctrl_q.detect_loopback;
    assign PIPE_TX_ELEC_IDLE       = ctrl_q.elec_idle;
    assign PIPE_POWERDOWN          = ctrl_q.powerdown;
    assign PIPE_RATE               = ctrl_q.rate;
    assign PIPE_TX_DEEMPH          = ctrl_q.deemph;
    assign TX_EQUALIZER_COEFFS     = ctrl_q.eq_coeffs;
    assign PIPE_TX_MARGIN          = ctrl_q.margin;
    assign PIPE_TX_SWING           = ctrl_q.swing;
    assign PIPE_RX_POLARITY        = ctrl_q.rx_polarity;

    comp_one_cycle_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        PIPE_TX_COMPLIANCE |=> !PIPE_TX_COMPLIANCE)
        else $error("compliance held longer than one cycle");
    no_p2_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        PIPE_POWERDOWN != PD_P2)
        else $error("unsupported P2 state driven");
    sync_hdr_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        PIPE_TX_BLK_START |-> (PIPE_TX_SYNC_HDR == SYNC_DATA ||
                               PIPE_TX_SYNC_HDR == SYNC_OS))
        else $error("bad sync header at block start");
    blk_gen3_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        PIPE_TX_BLK_START |-> PIPE_RATE[1])
        else $error("block start outside Gen3");
    data_follow_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        TX_VALID |=> PIPE_TX_DATA == $past(TX_DATA))
        else $error("transmit word not forwarded");
    skip_idle_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (!TX_VALID && is_gen3(rate_eff)) |=>
        PIPE_TX_DATA_VALID == SKIP_LEVEL)
        else $error("idle Gen3 cycle not skipped");
    idle_follow_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        ELEC_IDLE |=> PIPE_TX_ELEC_IDLE)
        else $error("electrical idle not forced");
    margin_rsvd_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        PIPE_TX_MARGIN[2:1] != 2'h1)
        else $error("reserved margin code driven");
endmodule : pipe_tx_ctrl

// [test/phy_model.sv]
// Behavioural PHY taking the controller's transmit-side inputs
`timescale 1ns/10ps
module phy_model
    import pipe_tx_pkg::*;
(
    // Clock and reset
    input  wire logic     clk,
    input  wire logic     rst_n,
    // Transmit inputs and observed state
    input  wire tx_word_t tx,
    input  wire tx_ctrl_t ctrl,
    output logic [15:0]   used_q,
    output logic [1:0]    hdr_q,
    output logic          neg_disp_q,
    output logic [8:0]    sym0_q,
    output logic          eff_deemph
);
    wire logic gen3 = ctrl.rate[1];
    wire logic skip = gen3 && tx.data_valid == SKIP_LEVEL;
    wire logic off  = ctrl.elec_idle || ctrl.powerdown != PD_P0;

    // Gen3-capable build: fixed de-emphasis below Gen3
    assign eff_deemph = ctrl.rate[0] ? DEEMPH_6DB : DEEMPH_35DB;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            used_q     <= 16'h0;
            hdr_q      <= 2'h0;
            neg_disp_q <= 1'h0;
            sym0_q     <= 9'h0;
        end else begin
            if (!skip && !off)
                used_q <= used_q + 16'h1;
            if (gen3 && tx.blk_start)
                hdr_q <= tx.sync_hdr;
            if (tx.compliance && !gen3)
                neg_disp_q <= 1'h1;
            if (!skip)
                sym0_q <= {tx.datak[0], tx.data[7:0]};
        end
    end
endmodule : phy_model

// [test/tb.sv]
// Self-checking bench for the PIPE transmit-side controller
`timescale 1ns/10ps
module tb;
    import pipe_tx_pkg::*;
    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  isc;
        logic        valid, bs, os, comp;
        logic [1:0]  rate, pd;
        logic        ei, det, de;
        logic [5:0]  cm, c0, cp;
        logic [2:0]  mg;
        logic        sw, inv;
    } stim_t;
    logic        SYS_CLK, RESETN, TX_READY, CTRL_REJECT, pc, mneg, mde;
    stim_t       s, p, n, w;
    wire tx_word_t txo;
    wire tx_ctrl_t cto;
    logic [1:0]  epd, mhdr;
    logic [2:0]  emg;
    logic [8:0]  msym;
    logic [15:0] mused, used0;
    logic [95:0] r;
    logic [31:0] seed = 32'h0000088c;
    int          num_errors = 0;
    int          tests_run = 0;
    int          cycles = 0;

    pipe_tx_ctrl #(.WIDTH(DATA_W)) pipe_tx_ctrl_i (
        .SYS_CLK(SYS_CLK), .RESETN(RESETN), .TX_DATA(s.data),
        .TX_IS_CTRL(s.isc), .TX_VALID(s.valid), .TX_READY(TX_READY),
        .TX_BLOCK_START(s.bs), .TX_OS_BLOCK(s.os), .TX_COMPLIANCE(s.comp),
        .RATE(s.rate), .POWER_STATE(s.pd), .ELEC_IDLE(s.ei),
        .DETECT_REQ(s.det), .DEEMPH_35(s.de), .C_MINUS(s.cm), .C_ZERO(s.c0),
        .C_PLUS(s.cp), .MARGIN(s.mg), .LOW_SWING(s.sw), .RX_INVERT(s.inv),
        .CTRL_REJECT(CTRL_REJECT), .PIPE_TX_DATA(txo.data),
        .PIPE_TX_DATAK(txo.datak), .PIPE_TX_COMPLIANCE(txo.compliance),
        .PIPE_TX_DATA_VALID(txo.data_valid), .PIPE_TX_BLK_START(txo.blk_start),
        .PIPE_TX_SYNC_HDR(txo.sync_hdr), .PIPE_TX_ELEC_IDLE(cto.elec_idle),
        .PIPE_TX_DETECT_LOOPBACK(cto.detect_loopback),
        .PIPE_POWERDOWN(cto.powerdown), .PIPE_RATE(cto.rate),
        .PIPE_TX_DEEMPH(cto.deemph), .TX_EQUALIZER_COEFFS(cto.eq_coeffs),
        .PIPE_TX_MARGIN(cto.margin), .PIPE_TX_SWING(cto.swing),
        .PIPE_RX_POLARITY(cto.rx_polarity));
    phy_model phy_model_i (.clk(SYS_CLK), .rst_n(RESETN), .tx(txo),
        .ctrl(cto), .used_q(mused), .hdr_q(mhdr), .neg_disp_q(mneg),
        .sym0_q(msym), .eff_deemph(mde));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic compare(input string nm, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : compare

    task automatic check_out();
        logic g3;
        g3 = p.rate[1];
        if (p.valid) compare("data", p.data, txo.data);
        if (p.valid) compare("datak", p.isc, txo.datak);
        compare("compl", p.comp && !pc && !g3, txo.compliance);
        compare("dvalid", g3 ? !p.valid : 1'b1, txo.data_valid);
        compare("blk", p.bs && p.valid, txo.blk_start);
        compare("ready", 32'h1, TX_READY);
        if (!g3) compare("fixdeemph", p.rate[0] ? DEEMPH_6DB : DEEMPH_35DB,
            mde);
        compare("hdr", !p.bs ? 2'h0 : p.os ? SYNC_OS : SYNC_DATA,
            txo.sync_hdr);
        compare("detect", p.det, cto.detect_loopback);
        compare("idle", p.ei || (!g3 && !p.valid), cto.elec_idle);
        compare("pd", epd, cto.powerdown);
        compare("deemph", p.de, cto.deemph);
        compare("coef", {p.cp, p.c0, p.cm}, cto.eq_coeffs);
        compare("margin", emg, cto.margin);
        compare("swing", p.sw, cto.swing);
        compare("rxpol", p.inv, cto.rx_polarity);
        compare("rate", p.rate, cto.rate);
    endtask : check_out

    task automatic step(input stim_t nx);
        @(posedge SYS_CLK);
        #1;
        p = s;
        if (p.pd != PD_P2) epd = p.pd;
        if (p.mg[2:1] != 2'h1) emg = p.mg;
        check_out();
        pc = p.comp;
        s = nx;
        #1;
        compare("reject", s.pd == PD_P2 || s.mg[2:1] == 2'h1,
            CTRL_REJECT);
    endtask : step

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    initial begin
        SYS_CLK = 1'b0;
        forever #12.5 SYS_CLK = ~SYS_CLK;
    end

    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            results();
        end
    end

    initial begin
        s = '0;
        RESETN = 1'b0;
        epd = PD_P1;
        emg = 3'h0;
        pc = 1'b0;
        repeat (2) @(posedge SYS_CLK);
        #1;
        compare("rst_idle", 32'h1, cto.elec_idle);
        compare("rst_pd", PD_P1, cto.powerdown);
        compare("rst_dv", 32'h0, txo.data_valid);
        RESETN = 1'b1;
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            r = {xs(), xs(), xs()};
            n = stim_t'(r[69:0]);
            n.valid = 1'b1;
            n.bs = 1'b0;
            n.isc = 4'(i);
            n.rate = 2'(i % 3);
            n.pd = i[1:0];
            n.mg = i[2:0];
            n.comp = i[0];
            step(n);
        end
        n = '0;
        n.rate = RATE_GEN3;
        repeat (3) step(n);
        compare("neg_disp", 32'h1, mneg);
        $display("test codes done");
        used0 = mused;
        for (int k = 0; k < 5; k++) begin
            n.valid = (k != 2);
            n.bs = (k == 0) || (k == 3);
            n.os = (k != 3);
            n.data = xs();
            n.isc = 4'(k + 1);
            w = n;
            step(n);
        end
        n.valid = 1'b0;
        n.bs = 1'b0;
        repeat (3) step(n);
        compare("used", 16'h4, mused - used0);
        compare("mhdr", SYNC_DATA, mhdr);
        compare("sym0", {w.isc[0], w.data[7:0]}, msym);
        $display("test gen3 done");
        for (int k = 0; k < 300; k++) begin
            r = {xs(), xs(), xs()};
            n = stim_t'(r[69:0]);
            if (!n.rate[1]) n.bs = 1'b0;
            step(n);
        end
        step(n);
        $display("test random done");
        results();
    end
endmodule : tb
